// [decrement_branch_nonzero_op_pkg.sv]
package dbnz_pkg;
  // opcode patterns
  localparam logic [4:0]  OPC_REG_HI   = 5'h1b;   // 11011rrr
  localparam logic [7:0]  OPC_DIRECT   = 8'hd5;   // 11010101
  localparam logic [15:0] LEN_REG      = 16'h0002;
  localparam logic [15:0] LEN_DIRECT   = 16'h0003;
  localparam int          EXEC_CYCLES  = 2;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [7:0]  DEC_STEP     = 8'h01;
  localparam logic [7:0]  SFR_BASE     = 8'h80;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [7:0]  PSW_RESET    = 8'h00;
  localparam int          REG_COUNT    = 8;       // registers in one bank

  // instruction bytes handed over by fetch
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } instr_t;

  // memory / port write request
  typedef struct packed {
    logic       wr_reg;
    logic       wr_dir;
    logic [7:0] addr;
    logic [7:0] data;
  } wr_req_t;
endpackage : dbnz_pkg

// [decrement_branch_nonzero_op_alu.sv]
`timescale 1ns/100ps
// decrement and target computation, purely combinational
module dbnz_alu (
  // operands
  input  wire logic [7:0]  operand,
  input  wire logic [7:0]  disp,
  input  wire logic [15:0] pc_next,
  // results
  output logic      [7:0]  result,
  output logic             nonzero,
  output logic      [15:0] target
);
  import dbnz_pkg::*;

  // wrap 00 to ff naturally in 8 bits
  assign result  = operand - DEC_STEP;
  assign nonzero = (result != ZERO_BYTE);
  // sign-extended displacement added to next pc
  assign target  = pc_next + {{8{disp[7]}}, disp};
endmodule : dbnz_alu

// [decrement_branch_nonzero_op_exec.sv]
`timescale 1ns/100ps
module decrement_branch_nonzero_exec (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // instruction start
  input  wire logic                  start,
  input  wire dbnz_pkg::instr_t      instr,
  input  wire logic [15:0]           pc_in,
  input  wire logic [7:0]            psw_in,
  // operand sources
  input  wire logic [63:0]           working_register_n,
  input  wire logic [7:0]            ram_rdata,
  input  wire logic [7:0]            port_latch_rdata,
  input  wire logic [7:0]            port_pin_rdata,
  input  wire logic                  dir_is_port,
  // results
  output dbnz_pkg::wr_req_t          wr_req,
  output logic      [15:0]           pc_out,
  output logic      [7:0]            psw_out,
  output logic                       pc_load,
  output logic                       taken,
  output logic                       done,
  output logic                       busy,
  output logic                       illegal
);
  import dbnz_pkg::*;

  // idle, operand fetch, write back and branch
  typedef enum logic [1:0] {IDLE, CYC1, CYC2} state_t;

  // sequencer state and registered outputs
  state_t      st_q, st_d;
  instr_t      ins_q, ins_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0]  psw_q, psw_d;
  logic [7:0]  op_q, op_d;
  wr_req_t     wr_q, wr_d;
  logic [15:0] pco_q, pco_d;
  logic        load_q, load_d;
  logic        tk_q, tk_d;
  logic        done_q, done_d;
  logic        ill_q, ill_d;
  logic        busy_q, busy_d;

  // decode and datapath nets
  logic        is_reg;
  logic        is_dir;
  logic [7:0]  operand;
  logic [7:0]  disp;
  logic [15:0] pc_next;
  // arithmetic results
  logic [7:0]  result;
  logic        nonzero;
  logic [15:0] target;
  logic [2:0]  rsel;
  logic [7:0]  bank_byte [REG_COUNT];
  logic [7:0]  wr_addr;

  // decode of the latched instruction
  assign is_reg = (ins_q.opcode[7:3] == OPC_REG_HI);
  assign is_dir = (ins_q.opcode == OPC_DIRECT);
  assign rsel   = ins_q.opcode[2:0];
  // write-back address: bank entry or the direct address byte
  assign wr_addr = is_reg ? {5'h00, rsel} : ins_q.byte1;
  assign disp   = is_dir ? ins_q.byte2 : ins_q.byte1;
  // next sequential address from instruction length
  assign pc_next = pc_q + (is_dir ? LEN_DIRECT : LEN_REG);

  // split the flat bank into one byte per working register
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_bank
    assign bank_byte[g] = working_register_n[g*8 +: 8];
  end

  // decrement and branch target arithmetic
  dbnz_alu u_alu (
    .operand (op_q),
    .disp    (disp),
    .pc_next (pc_next),
    .result  (result),
    .nonzero (nonzero),
    .target  (target)
  );

  // operand selection: register bank entry, port latch or ram
  always_comb begin
    // ram is the source unless a register or a port is named
    operand = ram_rdata;
    if (is_reg) begin
      operand = bank_byte[rsel];
    end else if (dir_is_port) begin
      operand = port_latch_rdata;
    end
  end

  // two-cycle sequence: fetch operand, then write back and branch
  always_comb begin
    // held values keep their contents; pulses default low
    st_d   = st_q;
    ins_d  = ins_q;
    pc_d   = pc_q;
    psw_d  = psw_q;
    op_d   = op_q;
    wr_d   = '0;
    pco_d  = pco_q;
    load_d = 1'b0;
    tk_d   = tk_q;
    done_d = 1'b0;
    ill_d  = 1'b0;
    unique case (st_q)
      // capture the request while idle
      IDLE: begin
        if (start) begin
          ins_d = instr;
          pc_d  = pc_in;
          psw_d = psw_in;
          st_d  = CYC1;
        end
      end
      // sample the operand; unknown opcodes end here
      CYC1: begin
        if (is_reg || is_dir) begin
          op_d = operand;
          st_d = CYC2;
        end else begin
          // no write and no pc load for an unknown opcode
          ill_d = 1'b1;
          done_d = 1'b1;
          st_d  = IDLE;
        end
      end
      // commit: write back, branch decision and pc load
      CYC2: begin
        // write back to the same location
        wr_d.wr_reg = is_reg;
        wr_d.wr_dir = is_dir;
        wr_d.addr   = wr_addr;
        wr_d.data   = result;
        // not taken falls through to sequential address
        pco_d  = nonzero ? target : pc_next;
        tk_d   = nonzero;
        load_d = 1'b1;
        done_d = 1'b1;
        // flags pass through untouched
        psw_d  = psw_q;
        st_d   = IDLE;
      end
      default: st_d = IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // everything returns to its idle value
      st_q   <= IDLE;
      ins_q  <= '0;
      pc_q   <= PC_RESET;
      psw_q  <= PSW_RESET;
      op_q   <= ZERO_BYTE;
      wr_q   <= '0;
      pco_q  <= PC_RESET;
      load_q <= 1'b0;
      tk_q   <= 1'b0;
      done_q <= 1'b0;
      ill_q  <= 1'b0;
    end else begin
      // take the next values
      st_q   <= st_d;
      ins_q  <= ins_d;
      pc_q   <= pc_d;
      psw_q  <= psw_d;
      op_q   <= op_d;
      wr_q   <= wr_d;
      pco_q  <= pco_d;
      load_q <= load_d;
      tk_q   <= tk_d;
      done_q <= done_d;
      ill_q  <= ill_d;
    end
  end

  // busy follows the state about to be entered
  always_comb begin
    busy_d = (st_d != IDLE);
  end

  // busy register, cleared on reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // every output comes straight from its flip-flop
  assign wr_req  = wr_q;
  assign pc_out  = pco_q;
  assign psw_out = psw_q;
  assign pc_load = load_q;
  assign taken   = tk_q;
  assign done    = done_q;
  assign busy    = busy_q;
  assign illegal = ill_q;

  // pin value is deliberately never used for the operand
  logic unused_pins;
  assign unused_pins = ^port_pin_rdata;
endmodule : decrement_branch_nonzero_exec

// [dec_branch_sva.sv]
`timescale 1ns/100ps
// port-level checks for the decrement-and-branch block
module dec_branch_sva
  import dbnz_pkg::*;
(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_b,
  // request
  input wire logic              start,
  input wire dbnz_pkg::instr_t  instr,
  input wire logic [15:0]       pc_in,
  input wire logic [7:0]        psw_in,
  // results
  input wire dbnz_pkg::wr_req_t wr_req,
  input wire logic [15:0]       pc_out,
  input wire logic [7:0]        psw_out,
  input wire logic              pc_load,
  input wire logic              taken,
  input wire logic              done,
  input wire logic              busy,
  input wire logic              illegal
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic        rg;
  logic        lg;
  logic [15:0] nx;
  logic [15:0] tg;
  logic [7:0]  dp;
  // accepted legal request, sequential pc and taken target
  assign rg = instr.opcode[7:3] == OPC_REG_HI;
  assign lg = start && !busy && (rg || instr.opcode == OPC_DIRECT);
  assign nx = pc_in + (rg ? LEN_REG : LEN_DIRECT);
  assign dp = rg ? instr.byte1 : instr.byte2;
  assign tg = nx + {{8{dp[7]}}, dp};
  property p_cyc;
    lg |-> ##1 !done ##1 !done ##1 (done && pc_load);
  endproperty
  a_cyc: assert property (p_cyc) else $error("completion not 2 cycles");
  property p_wr; pc_load |-> wr_req.wr_reg || wr_req.wr_dir; endproperty
  a_wr: assert property (p_wr) else $error("no write-back");
  property p_br; pc_load |-> taken == (wr_req.data != ZERO_BYTE); endproperty
  a_br: assert property (p_br) else $error("branch vs result");
  property p_wrap; pc_load && wr_req.data == 8'hff |-> taken; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap not taken");
  property p_psw; lg |-> ##2 psw_out == $past(psw_in, 2); endproperty
  a_psw: assert property (p_psw) else $error("flags changed");
  property p_reg;
    lg && rg |-> ##3 wr_req.wr_reg &&
      wr_req.addr == {5'h00, $past(instr.opcode[2:0], 3)};
  endproperty
  a_reg: assert property (p_reg) else $error("reg write");
  property p_dir;
    lg && !rg |-> ##3 wr_req.wr_dir && wr_req.addr == $past(instr.byte1, 3);
  endproperty
  a_dir: assert property (p_dir) else $error("direct write");
  property p_seq; lg |-> ##3 (taken || pc_out == $past(nx, 3)); endproperty
  a_seq: assert property (p_seq) else $error("next pc");
  property p_tgt; lg |-> ##3 (!taken || pc_out == $past(tg, 3)); endproperty
  a_tgt: assert property (p_tgt) else $error("branch target");
  property p_ill;
    illegal |-> done && !pc_load && !wr_req.wr_reg && !wr_req.wr_dir;
  endproperty
  a_ill: assert property (p_ill) else $error("unknown opcode");
endmodule : dec_branch_sva

// [tb_decrement_branch_nonzero_exec.sv]
`timescale 1ns/100ps
// self-checking bench for the decrement-and-branch block
module tb_decrement_branch_nonzero_exec;
  import dbnz_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, start = 1'b0, dir_is_port = 1'b0;
  logic pc_load, taken, done, busy, illegal;
  logic [63:0] working_register_n = '0;
  logic [15:0] pc_in = '0, pc_out;
  logic [7:0]  psw_in = '0, ram_rdata = '0, port_latch_rdata = '0;
  logic [7:0]  port_pin_rdata = '0, psw_out;
  instr_t      instr = '0;
  wr_req_t     wr_req;
  int          err_total = 0, comparisons = 0, cyc = 0;
  decrement_branch_nonzero_exec DUT (.sys_clk, .rst_b, .start, .instr,
    .pc_in, .psw_in, .working_register_n, .ram_rdata, .port_latch_rdata,
    .port_pin_rdata, .dir_is_port, .wr_req, .pc_out, .psw_out, .pc_load,
    .taken, .done, .busy, .illegal);
  always #50 sys_clk = ~sys_clk;
  // compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one instruction from pc 1000h, operand v in the chosen source
  task automatic run(input logic [7:0] op, b1, b2, v, input logic prt,
                     input logic [7:0] ed, input logic [15:0] ep,
                     input logic et);
    int n;
    logic [7:0] ea;
    logic       rf;
    rf = (op[7:3] == OPC_REG_HI);
    ea = rf ? {5'h00, op[2:0]} : b1;
    @(negedge sys_clk);
    start = 1'b1;
    instr = '{op, b1, b2};
    pc_in = 16'h1000;
    psw_in = 8'hc4;
    working_register_n = {8{8'h33}};
    working_register_n[op[2:0]*8 +: 8] = v;
    ram_rdata = prt ? 8'h77 : v;
    port_latch_rdata = prt ? v : 8'h77;
    port_pin_rdata = ~v;
    dir_is_port = prt;
    @(negedge sys_clk);
    start = 1'b0;
    chk({15'h0000, busy}, 16'h0001);
    for (n = 0; n < 4 && done !== 1'b1; n++) @(negedge sys_clk);
    chk(16'(n), 16'(EXEC_CYCLES));
    chk({8'h00, wr_req.data}, {8'h00, ed});
    chk({6'h00, wr_req.wr_reg, wr_req.wr_dir, wr_req.addr},
        {6'h00, rf, !rf, ea});
    chk({13'h0000, illegal, pc_load, taken},
        {13'h0000, 1'b0, 1'b1, et});
    chk(pc_out, ep);
    chk({8'h00, psw_out}, 16'h00c4);
  endtask : run
  task automatic t_reg_back;
    run(8'hdb, 8'hfe, 8'h00, 8'h05, 1'b0, 8'h04, 16'h1000, 1'b1);
    $display("test t_reg_back done");
  endtask : t_reg_back
  task automatic t_reg_zero;
    run(8'hdf, 8'h10, 8'h00, 8'h01, 1'b0, 8'h00, 16'h1002, 1'b0);
    $display("test t_reg_zero done");
  endtask : t_reg_zero
  task automatic t_dir_wrap;
    run(8'hd5, 8'h30, 8'h10, 8'h00, 1'b0, 8'hff, 16'h1013, 1'b1);
    $display("test t_dir_wrap done");
  endtask : t_dir_wrap
  task automatic t_port;
    run(8'hd5, 8'h90, 8'h80, 8'h02, 1'b1, 8'h01, 16'h0f83, 1'b1);
    $display("test t_port done");
  endtask : t_port
  // reset in mid-instruction returns every output to zero
  task automatic t_reset;
    @(negedge sys_clk);
    start = 1'b1;
    instr = '{8'hdb, 8'h02, 8'h00};
    @(negedge sys_clk);
    start = 1'b0;
    rst_b = 1'b0;
    @(negedge sys_clk);
    chk({11'h000, pc_load, taken, done, busy, illegal}, 16'h0000);
    chk(pc_out, PC_RESET);
    chk({8'h00, psw_out}, {8'h00, PSW_RESET});
    rst_b = 1'b1;
    $display("test t_reset done");
  endtask : t_reset
  // an unknown opcode ends after one cycle with no write
  task automatic t_illegal;
    @(negedge sys_clk);
    start = 1'b1;
    instr = '{8'h00, 8'h40, 8'h02};
    @(negedge sys_clk);
    start = 1'b0;
    @(negedge sys_clk);
    chk({11'h000, done, illegal, pc_load, wr_req.wr_reg, wr_req.wr_dir},
        16'h0018);
    $display("test t_illegal done");
  endtask : t_illegal
  // verdict and end of run
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 200) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    t_reg_back();
    t_reg_zero();
    t_dir_wrap();
    t_port();
    t_reset();
    t_illegal();
    tally_and_finish();
  end
endmodule : tb_decrement_branch_nonzero_exec
bind decrement_branch_nonzero_exec dec_branch_sva u_sva (.sys_clk, .rst_b,
  .start, .instr, .pc_in, .psw_in, .wr_req, .pc_out, .psw_out, .pc_load,
  .taken, .done, .busy, .illegal);
